// file: hdl/jbuf_pkg.sv
// Purpose: Shared constants for the packet jitter buffer and its statistics
// Assumes: One 100 MHz clock, packets carried as single words
// Notes: Times held in their own unit, cycle counts derived from them
package jbuf_pkg;
    localparam int CLK_MHZ = 100;
    localparam int DATA_W = 32;
    localparam int DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] MIDPOINT = 4'h4;
    localparam logic [CNT_W-1:0] FULL_LEVEL = 4'h8;
    localparam int SEC_MS = 1000;
    localparam int MS_US = 1000;
    localparam int MS_CYCLES = MS_US * CLK_MHZ;
    localparam int INTERVAL_SEC = 300;
    localparam int MS_CNT_W = 17;
    localparam int SEC_CNT_W = 10;
    localparam int STAT_W = 16;
    localparam logic [STAT_W-1:0] STAT_RESET = 16'h0000;
    localparam logic [SEC_CNT_W-1:0] SEC_RESET = 10'h000;
    typedef enum logic [1:0] {ST_FILL, ST_PLAY, ST_FLUSH} play_state_e;
endpackage

// file: hdl/jbuf_fifo.sv
// Purpose: Parameterised FIFO with valid/ready on both sides and flush
// Assumes: Synchronous flush empties the store in one cycle
// Notes: Read data come from a register
`timescale 1ns/1ps
`default_nettype none
module jbuf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Write side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Read side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [AW:0] level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    logic do_wr;
    logic do_rd;

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign do_wr = in_valid && in_ready && !flush;
    assign do_rd = out_valid && out_ready && !flush;
    assign level = cnt_reg;

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else if (flush) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_wr) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (do_rd) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // Registered head word, shown from the cycle after store holds it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (flush) begin
            out_valid <= 1'b0;
        end else if (!out_valid || do_rd) begin
            out_valid <= 1'b0;
            if (cnt_reg != '0 && !(do_rd && cnt_reg == (AW+1)'(1))) begin
                out_valid <= 1'b1;
                out_data <= mem[do_rd ? rptr_reg + 1'b1 : rptr_reg];
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/jitter_buffer.sv
// Purpose: Packet jitter buffer with overflow flush and interval statistics
// Assumes: Network side presents one packet word per valid beat; TDM side pulls
// Notes: Play-out waits until the buffer reaches its midpoint
`timescale 1ns/1ps
`default_nettype none
module jitter_buffer
    import jbuf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Network side
    input wire logic pkt_valid,
    input wire logic [DATA_W-1:0] pkt_data,
    // TDM play-out side
    input wire logic play_ready,
    output logic play_valid,
    output logic [DATA_W-1:0] play_data,
    // Statistics
    input wire logic stats_clear,
    output logic overflow_pulse,
    output logic underflow_pulse,
    output logic [STAT_W-1:0] overflow_secs,
    output logic [STAT_W-1:0] underflow_count,
    output logic [STAT_W-1:0] max_dev_ms,
    output logic [SEC_CNT_W-1:0] interval_secs
);
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic srst_n;
    play_state_e state_reg;
    logic flush;
    logic overflow_hit;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [DATA_W-1:0] fifo_out_data;
    logic [CNT_W-1:0] level;
    logic [MS_CNT_W-1:0] ms_cnt_reg;
    logic [9:0] ms_in_sec_reg;
    logic ms_tick;
    logic sec_tick;
    logic ovf_this_sec_reg;
    logic [CNT_W-1:0] dev_now;
    logic [CNT_W-1:0] dev_peak_reg;
    logic [STAT_W-1:0] dev_ms_reg;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign srst_n = rst_sync_reg;

    function automatic logic [CNT_W-1:0] abs_diff(input logic [CNT_W-1:0] a,
                                                 input logic [CNT_W-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // Arrival while full, outside the flush cycle, is an overflow; the packet is dropped
    assign overflow_hit = pkt_valid && (level == FULL_LEVEL) && (state_reg != ST_FLUSH);
    assign flush = (state_reg == ST_FLUSH);
    assign fifo_out_ready = (state_reg == ST_PLAY) && play_ready;

    jbuf_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH),
        .AW(PTR_W)
    ) u_fifo (
        .clk(clk),
        .rst_n(srst_n),
        .flush(flush),
        .in_valid(pkt_valid),
        .in_ready(fifo_in_ready),
        .in_data(pkt_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(level)
    );

    // Play-out state
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            state_reg <= ST_FILL;
        end else begin
            case (state_reg)
                ST_FILL: begin
                    if (overflow_hit) begin
                        state_reg <= ST_FLUSH;
                    end else if (level >= MIDPOINT) begin
                        state_reg <= ST_PLAY;
                    end
                end
                ST_PLAY: begin
                    if (overflow_hit) begin
                        state_reg <= ST_FLUSH;
                    end else if (level == '0) begin
                        state_reg <= ST_FILL;
                    end
                end
                ST_FLUSH: state_reg <= ST_FILL;
                default: state_reg <= ST_FILL;
            endcase
        end
    end

    // Registered play-out port
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            play_valid <= 1'b0;
            play_data <= '0;
        end else begin
            play_valid <= fifo_out_valid && fifo_out_ready;
            play_data <= fifo_out_data;
        end
    end

    // Event pulses: each overflow gives one forced underflow
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            overflow_pulse <= 1'b0;
            underflow_pulse <= 1'b0;
        end else begin
            overflow_pulse <= overflow_hit;
            underflow_pulse <= flush || (state_reg == ST_PLAY && level == '0 && !overflow_hit);
        end
    end

    // Millisecond and second enables
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ms_cnt_reg <= '0;
            ms_in_sec_reg <= '0;
        end else if (ms_cnt_reg == MS_CNT_W'(MS_CYCLES - 1)) begin
            ms_cnt_reg <= '0;
            ms_in_sec_reg <= (ms_in_sec_reg == 10'(SEC_MS - 1)) ? '0 : ms_in_sec_reg + 1'b1;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 1'b1;
        end
    end
    assign ms_tick = (ms_cnt_reg == MS_CNT_W'(MS_CYCLES - 1));
    assign sec_tick = ms_tick && (ms_in_sec_reg == 10'(SEC_MS - 1));

    // Interval seconds
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            interval_secs <= SEC_RESET;
        end else if (stats_clear) begin
            interval_secs <= SEC_RESET;
        end else if (sec_tick) begin
            if (interval_secs == SEC_CNT_W'(INTERVAL_SEC - 1)) begin
                interval_secs <= SEC_RESET;
            end else begin
                interval_secs <= interval_secs + 1'b1;
            end
        end
    end

    // Overflow seconds; an overflow in the tick cycle still counts
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ovf_this_sec_reg <= 1'b0;
            overflow_secs <= STAT_RESET;
        end else if (stats_clear) begin
            ovf_this_sec_reg <= overflow_hit;
            overflow_secs <= STAT_RESET;
        end else if (sec_tick) begin
            ovf_this_sec_reg <= 1'b0;
            if (ovf_this_sec_reg || overflow_hit) begin
                overflow_secs <= overflow_secs + 1'b1;
            end
        end else if (overflow_hit) begin
            ovf_this_sec_reg <= 1'b1;
        end
    end

    // Underflows, forced ones included
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            underflow_count <= STAT_RESET;
        end else if (stats_clear) begin
            // An underflow in the clear cycle is kept
            underflow_count <= STAT_W'(flush || (state_reg == ST_PLAY && level == '0 && !overflow_hit));
        end else if (flush || (state_reg == ST_PLAY && level == '0 && !overflow_hit)) begin
            underflow_count <= underflow_count + 1'b1;
        end
    end

    // Deviation: ms spent away from midpoint during play, peak kept per interval
    assign dev_now = abs_diff(level, MIDPOINT);
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            dev_peak_reg <= '0;
            dev_ms_reg <= STAT_RESET;
            max_dev_ms <= STAT_RESET;
        end else begin
            dev_peak_reg <= (dev_now > dev_peak_reg) ? dev_now : dev_peak_reg;
            if (dev_now == '0 || state_reg != ST_PLAY) begin
                dev_ms_reg <= STAT_RESET;
                dev_peak_reg <= '0;
            end else if (ms_tick) begin
                dev_ms_reg <= dev_ms_reg + 1'b1;
            end
            if (stats_clear || (sec_tick && interval_secs == SEC_CNT_W'(INTERVAL_SEC - 1))) begin
                max_dev_ms <= STAT_RESET;
            end else if (dev_ms_reg > max_dev_ms) begin
                max_dev_ms <= dev_ms_reg;
            end
        end
    end

    sequence s_overflow;
        overflow_hit;
    endsequence
    sequence s_flush_then_fill;
        (state_reg == ST_FLUSH) ##1 (state_reg == ST_FILL);
    endsequence

    AST_OVF_FLUSH: assert property (@(posedge clk) disable iff (!srst_n)
        s_overflow |=> s_flush_then_fill) else $error("overflow not followed by flush");
    AST_FORCED_UF: assert property (@(posedge clk) disable iff (!srst_n)
        overflow_hit |-> ##2 underflow_pulse) else $error("no forced underflow");
    AST_EMPTY_AFTER: assert property (@(posedge clk) disable iff (!srst_n)
        (state_reg == ST_FLUSH) |=> (level == '0 && state_reg == ST_FILL))
        else $error("buffer not empty after flush");
    AST_MID_START: assert property (@(posedge clk) disable iff (!srst_n)
        (state_reg == ST_FILL && $past(state_reg) == ST_FILL) ##1 (state_reg == ST_PLAY)
        |-> $past(level) >= MIDPOINT) else $error("play started below midpoint");
    AST_OVF_PULSE: assert property (@(posedge clk) disable iff (!srst_n)
        (pkt_valid && level == FULL_LEVEL && state_reg != ST_FLUSH) |=> overflow_pulse)
        else $error("overflow not flagged");
    AST_DROP: assert property (@(posedge clk) disable iff (!srst_n)
        overflow_hit |=> level <= FULL_LEVEL) else $error("level above capacity");
    AST_SECS: assert property (@(posedge clk) disable iff (!srst_n)
        (sec_tick && !stats_clear && interval_secs < SEC_CNT_W'(INTERVAL_SEC - 1))
        |=> interval_secs == $past(interval_secs) + 1'b1) else $error("seconds not counted");
    AST_WRAP: assert property (@(posedge clk) disable iff (!srst_n)
        (sec_tick && interval_secs == SEC_CNT_W'(INTERVAL_SEC - 1)) |=>
        (interval_secs == '0 && max_dev_ms == '0)) else $error("interval not reset");
    AST_UF_COUNT: assert property (@(posedge clk) disable iff (!srst_n)
        (flush && !stats_clear) |=> underflow_count == $past(underflow_count) + 1'b1)
        else $error("forced underflow not counted");
    AST_OVF_SEC: assert property (@(posedge clk) disable iff (!srst_n)
        (sec_tick && overflow_hit && !stats_clear) |=>
        overflow_secs == $past(overflow_secs) + 1'b1) else $error("overflow second lost");
    AST_MAXDEV: assert property (@(posedge clk) disable iff (!srst_n)
        (!stats_clear && !sec_tick) |=> max_dev_ms >= $past(max_dev_ms))
        else $error("max deviation fell inside interval");
endmodule
`default_nettype wire

// file: testbench/jbuf_net_tdm_model.sv
// Purpose: Far-side model, network ingress bursts and TDM play-out pull
// Assumes: Inputs of the buffer change on the falling clock edge
// Notes: Idle packet data shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module jbuf_net_tdm_model
    import jbuf_pkg::*;
(
    // Clock
    input wire logic clk,
    // Network side
    output logic pkt_valid,
    output logic [DATA_W-1:0] pkt_data,
    // TDM side
    output logic play_ready,
    input wire logic play_valid,
    input wire logic [DATA_W-1:0] play_data
);
    // Pull mode: 0 stalled, 1 every cycle, 2 every other cycle
    int ready_mode = 0;
    logic [DATA_W-1:0] rx[$];

    initial begin
        pkt_valid = 1'b0;
        pkt_data = 32'h0000_0000;
        play_ready = 1'b0;
    end

    always @(negedge clk) begin
        play_ready <= (ready_mode == 1) ? 1'b1 : (ready_mode == 2) ? ~play_ready : 1'b0;
    end

    always @(posedge clk) begin
        if (play_valid === 1'b1) begin
            rx.push_back(play_data);
        end
    end

    // Back-to-back burst of n words counting up from base
    task automatic send_seq(input logic [DATA_W-1:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            pkt_valid = 1'b1;
            pkt_data = base + DATA_W'(i);
        end
        @(negedge clk);
        pkt_valid = 1'b0;
        pkt_data = ~pkt_data;
    endtask
endmodule
`default_nettype wire

// file: testbench/packet_jitter_buffer_monitor_tb.sv
// Purpose: Self-checking bench for the packet jitter buffer
// Assumes: Statistics seconds and milliseconds are too long to run out here
// Notes: Overflow and underflow pulses are timed by a cycle counter
`timescale 1ns/1ps
`default_nettype none
module packet_jitter_buffer_monitor_tb;
    import jbuf_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic stats_clear = 1'b0;
    logic pkt_valid;
    logic [DATA_W-1:0] pkt_data;
    logic play_ready;
    logic play_valid;
    logic [DATA_W-1:0] play_data;
    logic overflow_pulse;
    logic underflow_pulse;
    logic [STAT_W-1:0] overflow_secs;
    logic [STAT_W-1:0] underflow_count;
    logic [STAT_W-1:0] max_dev_ms;
    logic [SEC_CNT_W-1:0] interval_secs;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int ov_n = 0;
    int uf_n = 0;
    int ov_at = 0;
    int uf_at = 0;

    always #5 clk = ~clk;

    jitter_buffer dut_u (
        .clk(clk), .rst_n(rst_n), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .play_ready(play_ready), .play_valid(play_valid), .play_data(play_data),
        .stats_clear(stats_clear), .overflow_pulse(overflow_pulse),
        .underflow_pulse(underflow_pulse), .overflow_secs(overflow_secs),
        .underflow_count(underflow_count), .max_dev_ms(max_dev_ms),
        .interval_secs(interval_secs)
    );

    jbuf_net_tdm_model model_u (
        .clk(clk), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .play_ready(play_ready), .play_valid(play_valid), .play_data(play_data)
    );

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (overflow_pulse === 1'b1) begin
            ov_n <= ov_n + 1;
            ov_at <= cyc;
        end
        if (underflow_pulse === 1'b1) begin
            uf_n <= uf_n + 1;
            uf_at <= cyc;
        end
    end

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wait_rx(input int n);
        for (int i = 0; i < 60 && model_u.rx.size() < n; i++) begin
            @(negedge clk);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic test_reset();
        repeat (4) @(negedge clk);
        check(32'(underflow_pulse), 32'h0, "underflow idle");
        check(32'(play_valid), 32'h0, "play valid idle");
        check(32'(overflow_pulse), 32'h0, "overflow idle");
        check(32'(underflow_count), 32'h0, "underflow count at reset");
        check(32'(interval_secs), 32'h0, "interval secs at reset");
    endtask

    // Play-out held back until midpoint, then words in arrival order
    task automatic test_fill_to_mid();
        model_u.ready_mode = 1;
        model_u.rx.delete();
        model_u.send_seq(32'ha000_0000, 3);
        repeat (12) @(negedge clk);
        check(32'(model_u.rx.size()), 32'h0, "play before midpoint");
        model_u.send_seq(32'ha000_0003, 1);
        wait_rx(4);
        check(32'(model_u.rx.size()), 32'h4, "words played");
        for (int i = 0; i < 4 && i < model_u.rx.size(); i++) begin
            check(model_u.rx[i], 32'ha000_0000 + 32'(i), "play order");
        end
        check(32'(ov_n), 32'h0, "no overflow below capacity");
        model_u.ready_mode = 0;
        repeat (4) @(negedge clk);
    endtask

    // Burst past capacity: drop, flush, one forced underflow, refill
    task automatic test_overflow();
        logic [STAT_W-1:0] base;
        model_u.send_seq(32'hc000_0000, DEPTH);
        repeat (2) @(negedge clk);
        base = underflow_count;
        ov_n = 0;
        uf_n = 0;
        model_u.send_seq(32'hc000_0008, 1);
        repeat (6) @(negedge clk);
        check(32'(ov_n), 32'h1, "overflow pulses");
        check(32'(uf_n), 32'h1, "forced underflow pulses");
        check(32'(uf_at - ov_at), 32'h1, "underflow follows overflow");
        check(32'(underflow_count), 32'(base) + 32'h1, "underflow count step");
        model_u.rx.delete();
        model_u.ready_mode = 2;
        model_u.send_seq(32'hd000_0000, 4);
        wait_rx(4);
        check(32'(model_u.rx.size()), 32'h4, "words after refill");
        for (int i = 0; i < 4 && i < model_u.rx.size(); i++) begin
            check(model_u.rx[i], 32'hd000_0000 + 32'(i), "stale words flushed");
        end
        model_u.ready_mode = 0;
        repeat (6) @(negedge clk);
    endtask

    task automatic test_stats_clear();
        stats_clear = 1'b1;
        @(negedge clk);
        stats_clear = 1'b0;
        repeat (3) @(negedge clk);
        check(32'(overflow_secs), 32'h0, "overflow secs cleared");
        check(32'(underflow_count), 32'h0, "underflow count cleared");
        check(32'(max_dev_ms), 32'h0, "max deviation cleared");
        check(32'(interval_secs), 32'h0, "interval secs under one second");
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        test_reset();
        test_fill_to_mid();
        test_overflow();
        test_stats_clear();
        complete_run();
    end

    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
